// ==== core/pfw_map.svh ====
`ifndef PFW_MAP_SVH
`define PFW_MAP_SVH

// Register byte offsets on the AXI4-Lite bus.
`define PFW_OFF_ADDR_LO    8'h00
`define PFW_OFF_ADDR_HI    8'h04
`define PFW_OFF_DATA_LO    8'h08
`define PFW_OFF_DATA_HI    8'h0c
`define PFW_OFF_CTRL       8'h10
`define PFW_OFF_UNLOCK     8'h14

// Bit positions inside the control register.
`define PFW_CTRL_ERASE     0
`define PFW_CTRL_START     1
`define PFW_CTRL_WRITE_ENABLE_BIT      2
`define PFW_CTRL_ERR       3
`define PFW_CTRL_LATCH_ONLY_BIT      5
`define PFW_CTRL_CFGSEL    6

// Reset values and field widths.
`define PFW_CTRL_RESET     8'h00
`define PFW_ADDR_LO_RESET  8'h00
`define PFW_ADDR_HI_RESET  7'h00
`define PFW_DATA_LO_RESET  8'h00
`define PFW_DATA_HI_RESET  6'h00
`define PFW_LATCH_BLANK    14'h3fff
`define PFW_LATCH_CNT      6'h20

// Unlock keys written to the unlock register in this order.
`define PFW_KEY_FIRST      8'h55
`define PFW_KEY_SECOND     8'haa

// AXI response codes.
`define PFW_RESP_OKAY      2'h0
`define PFW_RESP_SLVERR    2'h2

`endif

// ==== core/pfw_pkg.sv ====
`default_nettype none
package pfw_pkg;
    typedef logic [13:0] pfw_word_t;
    typedef logic [4:0]  pfw_idx_t;
    typedef logic [9:0]  pfw_row_t;

    // Main sequencer states, one-hot.
    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_STREAM = 5'h02,
        ST_START  = 5'h04,
        ST_WAIT   = 5'h08,
        ST_CLEAR  = 5'h10
    } pfw_state_t;

    // Unlock sequence progress, one-hot.
    typedef enum logic [2:0] {
        UL_IDLE  = 3'h1,
        UL_KEY1  = 3'h2,
        UL_ARMED = 3'h4
    } pfw_unlock_t;
endpackage
`default_nettype wire

// ==== core/pfw_latch_if.sv ====
`default_nettype none
interface pfw_latch_if;
    import pfw_pkg::*;
    logic      we;
    pfw_idx_t  waddr;
    pfw_word_t wdata;
    pfw_idx_t  raddr;
    pfw_word_t rdata;
    logic      clear;

    modport ctl (output we, output waddr, output wdata, output raddr, output clear,
                 input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, input clear,
                 output rdata);
endinterface
`default_nettype wire

// ==== core/pfw_latch_mem.sv ====
`default_nettype none
`include "pfw_map.svh"
module pfw_latch_mem
    import pfw_pkg::*;
(
    input wire logic clk_in,    // Core clock.
    input wire logic rst_b_in,  // Asynchronous reset, active low.
    pfw_latch_if.mem lat        // Latch write, read and clear port.
);
    pfw_word_t mem_q [`PFW_LATCH_CNT];
    pfw_word_t rdata_q;

    // The whole bank returns to blank at reset or on a clear request.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            for (int i = 0; i < `PFW_LATCH_CNT; i++) begin
                mem_q[i] <= `PFW_LATCH_BLANK;
            end
        end else if (lat.clear) begin
            for (int i = 0; i < `PFW_LATCH_CNT; i++) begin
                mem_q[i] <= `PFW_LATCH_BLANK;
            end
        end else if (lat.we) begin
            mem_q[lat.waddr] <= lat.wdata;
        end
    end

    // Read data leaves through a register, one cycle after the address.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_q <= `PFW_LATCH_BLANK;
        end else begin
            rdata_q <= mem_q[lat.raddr];
        end
    end

    assign lat.rdata = rdata_q;
endmodule
`default_nettype wire

// ==== core/pfw_unlock.sv ====
`default_nettype none
`include "pfw_map.svh"
module pfw_unlock
    import pfw_pkg::*;
(
    input  wire logic       clk_in,     // Core clock.
    input  wire logic       rst_b_in,   // Asynchronous reset, active low.
    input  wire logic       wr_evt_in,  // One accepted register write.
    input  wire logic       is_key_in,  // That write targets the unlock register.
    input  wire logic [7:0] data_in,    // Low byte of the written data.
    output logic            armed_out   // Both keys seen with nothing between.
);
    pfw_unlock_t ul_q;

    // Any write other than the expected next key or a first key drops the sequence; a first key always restarts it.
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ul_q <= UL_IDLE;
        end else if (wr_evt_in) begin
            if (is_key_in && data_in == `PFW_KEY_FIRST) begin
                ul_q <= UL_KEY1;
            end else if (is_key_in && data_in == `PFW_KEY_SECOND && ul_q == UL_KEY1) begin
                ul_q <= UL_ARMED;
            end else begin
                ul_q <= UL_IDLE;
            end
        end
    end

    assign armed_out = (ul_q == UL_ARMED);
endmodule
`default_nettype wire

// ==== core/pfw_row_writer.sv ====
// Function
// - There are 32 write latches; the upper ten address bits pick the row, the low five the latch.
// - One programming operation never leaves the row chosen by the upper address bits.
// - After every program or erase operation all latches return to 0x3fff.
// - Starting programming does not erase the row first.
// - An erase always covers exactly one row.
// - A latch load or programming start happens only after an unbroken unlock sequence.
// - With the erase bit at 0 and the latch-only bit at 1 an unlock only copies the data pair into the addressed latch.
// - With the erase and latch-only bits at 0 an unlock loads the addressed latch and programs the whole row.
// - One up to 32 words may be written by one programming operation.
// - Latches not loaded before a commit stay blank and are programmed blank.
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`default_nettype none
`include "pfw_map.svh"
module pfw_row_writer
    import pfw_pkg::*;
(
    input  wire logic        CORE_CLK_IN,          // Core clock, 125 MHz.
    input  wire logic        RST_B_IN,             // Asynchronous reset, active low.
    input  wire logic        S_AXI_AWVALID_IN,     // Write address valid.
    output logic             S_AXI_AWREADY_OUT,    // Write address ready.
    input  wire logic [7:0]  S_AXI_AWADDR_IN,      // Write byte address.
    input  wire logic        S_AXI_WVALID_IN,      // Write data valid.
    output logic             S_AXI_WREADY_OUT,     // Write data ready.
    input  wire logic [31:0] S_AXI_WDATA_IN,       // Write data.
    input  wire logic [3:0]  S_AXI_WSTRB_IN,       // Write byte strobes.
    output logic             S_AXI_BVALID_OUT,     // Write response valid.
    input  wire logic        S_AXI_BREADY_IN,      // Write response ready.
    output logic [1:0]       S_AXI_BRESP_OUT,      // Write response code.
    input  wire logic        S_AXI_ARVALID_IN,     // Read address valid.
    output logic             S_AXI_ARREADY_OUT,    // Read address ready.
    input  wire logic [7:0]  S_AXI_ARADDR_IN,      // Read byte address.
    output logic             S_AXI_RVALID_OUT,     // Read data valid.
    input  wire logic        S_AXI_RREADY_IN,      // Read data ready.
    output logic [31:0]      S_AXI_RDATA_OUT,      // Read data.
    output logic [1:0]       S_AXI_RRESP_OUT,      // Read response code.
    input  wire logic        FLASH_BUSY_IN,        // Flash array busy, asynchronous.
    output logic [9:0]       FLASH_ROW_OUT,        // Target row of the operation.
    output logic [4:0]       FLASH_COL_OUT,        // Word within the row for a strobe.
    output logic [13:0]      FLASH_WDATA_OUT,      // Word offered with the strobe.
    output logic             FLASH_WSTB_OUT,       // One-cycle word strobe into the array.
    output logic             FLASH_PROG_OUT,       // Program-row request, held until busy.
    output logic             FLASH_ERASE_OUT,      // Erase-row request, held until busy.
    output logic             BUSY_OUT              // Sequencer busy level.
);
    // Synchroniser for the flash busy level.
    logic busy_meta_q;
    logic busy_sync_q;

    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            busy_meta_q <= 1'b0;
            busy_sync_q <= 1'b0;
        end else begin
            busy_meta_q <= FLASH_BUSY_IN;
            busy_sync_q <= busy_meta_q;
        end
    end

    // Bus side state.
    logic        awready_q;
    logic        wready_q;
    logic        aw_held_q;
    logic        w_held_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        arready_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        wr_fire;
    logic        wr_sel;
    logic        wr_mapped;
    // Software registers.
    logic [7:0]  addr_lo_q;
    logic [6:0]  addr_hi_q;
    logic [7:0]  data_lo_q;
    logic [5:0]  data_hi_q;
    logic        erase_sel_q;
    logic        write_enable_bit_q;
    logic        latch_only_bit_q;
    logic        cfgsel_q;
    logic        err_q;
    // Sequencer state.
    pfw_state_t  st_q;
    logic [5:0]  cnt_q;
    logic        pipe_v_q;
    pfw_idx_t    pipe_col_q;
    pfw_row_t    row_q;
    logic        op_erase_q;
    logic        wstb_q;
    pfw_idx_t    col_q;
    pfw_word_t   wdata_q;
    logic        prog_q;
    logic        erase_q;
    logic        busy_q;
    logic        armed;
    logic        start_req;
    logic        go;
    logic        go_erase;
    logic        bad_start;
    localparam logic [7:0] ctrl_rst = `PFW_CTRL_RESET;  // Control reset image, bit-addressable.

    pfw_latch_if lat ();

    // A write completes once address and data are both held.
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
    assign wr_sel  = wr_fire && w_strb_q[0];

    // Address decode for writes.
    assign wr_mapped = (aw_addr_q == `PFW_OFF_ADDR_LO) || (aw_addr_q == `PFW_OFF_ADDR_HI) ||
                       (aw_addr_q == `PFW_OFF_DATA_LO) || (aw_addr_q == `PFW_OFF_DATA_HI) ||
                       (aw_addr_q == `PFW_OFF_CTRL)    || (aw_addr_q == `PFW_OFF_UNLOCK);

    // Write address channel, one write outstanding at a time.
    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            awready_q <= 1'b1;
            aw_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (S_AXI_AWVALID_IN && awready_q) begin
            awready_q <= 1'b0;
            aw_held_q <= 1'b1;
            aw_addr_q <= S_AXI_AWADDR_IN;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end else if (bvalid_q && S_AXI_BREADY_IN) begin
            awready_q <= 1'b1;
        end
    end

    // Write data channel, taken independently of the address.
    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            wready_q <= 1'b1;
            w_held_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (S_AXI_WVALID_IN && wready_q) begin
            wready_q <= 1'b0;
            w_held_q <= 1'b1;
            w_data_q <= S_AXI_WDATA_IN;
            w_strb_q <= S_AXI_WSTRB_IN;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end else if (bvalid_q && S_AXI_BREADY_IN) begin
            wready_q <= 1'b1;
        end
    end

    // Write response; unmapped addresses answer with a slave error.
    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `PFW_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_mapped ? `PFW_RESP_OKAY : `PFW_RESP_SLVERR;
        end else if (bvalid_q && S_AXI_BREADY_IN) begin
            bvalid_q <= 1'b0;
        end
    end

    // Read channel; the data word is sampled at the address handshake.
    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= `PFW_RESP_OKAY;
        end else if (S_AXI_ARVALID_IN && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= `PFW_RESP_OKAY;
            unique case (S_AXI_ARADDR_IN)
                `PFW_OFF_ADDR_LO: rdata_q <= {24'h000000, addr_lo_q};
                `PFW_OFF_ADDR_HI: rdata_q <= {25'h0, addr_hi_q};
                `PFW_OFF_DATA_LO: rdata_q <= {24'h000000, data_lo_q};
                `PFW_OFF_DATA_HI: rdata_q <= {26'h0, data_hi_q};
                `PFW_OFF_CTRL: begin
                    rdata_q <= {25'h0, cfgsel_q, latch_only_bit_q, 1'b0, err_q, write_enable_bit_q,
                                busy_q, erase_sel_q};
                end
                `PFW_OFF_UNLOCK: rdata_q <= 32'h0000_0000;
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= `PFW_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && S_AXI_RREADY_IN) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // Address and data pairs; the address low byte holds row bits and latch index.
    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            addr_lo_q <= `PFW_ADDR_LO_RESET;
            addr_hi_q <= `PFW_ADDR_HI_RESET;
            data_lo_q <= `PFW_DATA_LO_RESET;
            data_hi_q <= `PFW_DATA_HI_RESET;
        end else if (wr_sel) begin
            if (aw_addr_q == `PFW_OFF_ADDR_LO) addr_lo_q <= w_data_q[7:0];
            if (aw_addr_q == `PFW_OFF_ADDR_HI) addr_hi_q <= w_data_q[6:0];
            if (aw_addr_q == `PFW_OFF_DATA_LO) data_lo_q <= w_data_q[7:0];
            if (aw_addr_q == `PFW_OFF_DATA_HI) data_hi_q <= w_data_q[5:0];
        end
    end

    // Unlock tracker; every accepted write with the low byte strobe set steps or breaks the sequence.
    pfw_unlock u_unlock (
        .clk_in    (CORE_CLK_IN),
        .rst_b_in  (RST_B_IN),
        .wr_evt_in (wr_sel),
        .is_key_in (aw_addr_q == `PFW_OFF_UNLOCK),
        .data_in   (w_data_q[7:0]),
        .armed_out (armed)
    );

    // A start needs the armed unlock, write enable and program space selected.
    assign start_req = wr_sel && (aw_addr_q == `PFW_OFF_CTRL) && w_data_q[`PFW_CTRL_START];
    assign go        = start_req && armed && !busy_q &&
                       w_data_q[`PFW_CTRL_WRITE_ENABLE_BIT] && !w_data_q[`PFW_CTRL_CFGSEL];
    assign go_erase  = go && w_data_q[`PFW_CTRL_ERASE];
    assign bad_start = start_req && !busy_q && !go;

    // Control bits; a start refused while not busy sets the error flag and that set beats a clear.
    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            erase_sel_q <= ctrl_rst[`PFW_CTRL_ERASE];
            write_enable_bit_q      <= ctrl_rst[`PFW_CTRL_WRITE_ENABLE_BIT];
            latch_only_bit_q      <= ctrl_rst[`PFW_CTRL_LATCH_ONLY_BIT];
            cfgsel_q    <= ctrl_rst[`PFW_CTRL_CFGSEL];
            err_q       <= ctrl_rst[`PFW_CTRL_ERR];
        end else begin
            if (wr_sel && aw_addr_q == `PFW_OFF_CTRL) begin
                erase_sel_q <= w_data_q[`PFW_CTRL_ERASE];
                write_enable_bit_q      <= w_data_q[`PFW_CTRL_WRITE_ENABLE_BIT];
                latch_only_bit_q      <= w_data_q[`PFW_CTRL_LATCH_ONLY_BIT];
                cfgsel_q    <= w_data_q[`PFW_CTRL_CFGSEL];
            end
            if (bad_start) begin
                err_q <= 1'b1;
            end else if (wr_sel && aw_addr_q == `PFW_OFF_CTRL && !w_data_q[`PFW_CTRL_ERR]) begin
                err_q <= 1'b0;
            end
        end
    end

    // Latch port: load at an accepted start unless erasing, clear after each operation.
    always_comb begin
        lat.we    = go && !go_erase;
        lat.waddr = addr_lo_q[4:0];
        lat.wdata = {data_hi_q, data_lo_q};
        lat.raddr = cnt_q[4:0];
        lat.clear = (st_q == ST_CLEAR);
    end

    pfw_latch_mem u_latch (
        .clk_in   (CORE_CLK_IN),
        .rst_b_in (RST_B_IN),
        .lat      (lat)
    );

    // Sequencer: latch-only starts finish at once, commits stream the row then program it.
    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            st_q       <= ST_IDLE;
            cnt_q      <= 6'h00;
            row_q      <= 10'h000;
            op_erase_q <= 1'b0;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    if (go_erase) begin
                        st_q       <= ST_START;
                        op_erase_q <= 1'b1;
                        row_q      <= {addr_hi_q, addr_lo_q[7:5]};
                    end else if (go && !w_data_q[`PFW_CTRL_LATCH_ONLY_BIT]) begin
                        st_q       <= ST_STREAM;
                        op_erase_q <= 1'b0;
                        cnt_q      <= 6'h00;
                        row_q      <= {addr_hi_q, addr_lo_q[7:5]};
                    end
                end
                ST_STREAM: begin
                    if (cnt_q != `PFW_LATCH_CNT) begin
                        cnt_q <= cnt_q + 6'h01;
                    end else if (!pipe_v_q) begin
                        st_q <= ST_START;
                    end
                end
                ST_START: if (busy_sync_q) st_q <= ST_WAIT;
                ST_WAIT:  if (!busy_sync_q) st_q <= ST_CLEAR;
                ST_CLEAR: st_q <= ST_IDLE;
            endcase
        end
    end

    // Read pipeline: latch data arrive one cycle after the index is issued.
    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            pipe_v_q   <= 1'b0;
            pipe_col_q <= 5'h00;
        end else begin
            pipe_v_q   <= (st_q == ST_STREAM) && (cnt_q != `PFW_LATCH_CNT);
            pipe_col_q <= cnt_q[4:0];
        end
    end

    // Array outputs; every latch, loaded or blank, is offered for the row.
    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            wstb_q  <= 1'b0;
            col_q   <= 5'h00;
            wdata_q <= `PFW_LATCH_BLANK;
        end else begin
            wstb_q  <= pipe_v_q;
            col_q   <= pipe_col_q;
            wdata_q <= lat.rdata;
        end
    end

    // Program and erase requests stand until the array reports busy.
    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            prog_q  <= 1'b0;
            erase_q <= 1'b0;
        end else begin
            prog_q  <= (st_q == ST_START) && !busy_sync_q && !op_erase_q;
            erase_q <= (st_q == ST_START) && !busy_sync_q && op_erase_q;
        end
    end

    // Busy covers the whole operation, from the cycle after the start is taken.
    always_ff @(posedge CORE_CLK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            busy_q <= 1'b0;
        end else if (go && (go_erase || !w_data_q[`PFW_CTRL_LATCH_ONLY_BIT])) begin
            busy_q <= 1'b1;
        end else if (st_q == ST_CLEAR) begin
            busy_q <= 1'b0;
        end
    end

    assign S_AXI_AWREADY_OUT = awready_q;
    assign S_AXI_WREADY_OUT  = wready_q;
    assign S_AXI_BVALID_OUT  = bvalid_q;
    assign S_AXI_BRESP_OUT   = bresp_q;
    assign S_AXI_ARREADY_OUT = arready_q;
    assign S_AXI_RVALID_OUT  = rvalid_q;
    assign S_AXI_RDATA_OUT   = rdata_q;
    assign S_AXI_RRESP_OUT   = rresp_q;
    assign FLASH_ROW_OUT     = row_q;
    assign FLASH_COL_OUT     = col_q;
    assign FLASH_WDATA_OUT   = wdata_q;
    assign FLASH_WSTB_OUT    = wstb_q;
    assign FLASH_PROG_OUT    = prog_q;
    assign FLASH_ERASE_OUT   = erase_q;
    assign BUSY_OUT          = busy_q;
endmodule
`default_nettype wire

// ==== verif/pfw_rw_checker.sv ====
`default_nettype none
module pfw_rw_checker (
    input wire logic       CORE_CLK_IN,     // Clock.
    input wire logic       RST_B_IN,        // Reset.
    input wire logic       FLASH_BUSY_IN,   // Array busy.
    input wire logic [9:0] FLASH_ROW_OUT,   // Row.
    input wire logic [4:0] FLASH_COL_OUT,   // Column.
    input wire logic       FLASH_WSTB_OUT,  // Strobe.
    input wire logic       FLASH_PROG_OUT,  // Program.
    input wire logic       FLASH_ERASE_OUT, // Erase.
    input wire logic       BUSY_OUT         // Busy.
);
    // All checks run on the core clock and rest during reset.
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    a_strobe_in_busy: assert property (FLASH_WSTB_OUT |-> BUSY_OUT)
        else $error("word strobe outside busy");
    a_prog_not_erase: assert property (FLASH_PROG_OUT |-> BUSY_OUT && !FLASH_ERASE_OUT)
        else $error("program request without busy");
    a_erase_no_strobe: assert property (FLASH_ERASE_OUT |-> !FLASH_WSTB_OUT)
        else $error("strobe during erase");
    a_col_steps_one: assert property (FLASH_WSTB_OUT && $past(FLASH_WSTB_OUT)
        |-> FLASH_COL_OUT == $past(FLASH_COL_OUT) + 5'h01)
        else $error("column did not step by one");
    a_burst_from_zero: assert property ($rose(FLASH_WSTB_OUT) |-> FLASH_COL_OUT == 5'h00)
        else $error("burst not starting at column zero");
    a_row_held: assert property (BUSY_OUT && $past(BUSY_OUT) |-> $stable(FLASH_ROW_OUT))
        else $error("row changed during operation");
    a_prog_held: assert property (FLASH_PROG_OUT && !FLASH_BUSY_IN |=> FLASH_PROG_OUT)
        else $error("program request dropped early");
    a_busy_end_clean: assert property ($fell(BUSY_OUT)
        |-> !FLASH_PROG_OUT && !FLASH_ERASE_OUT && !FLASH_BUSY_IN)
        else $error("busy ended with array active");
    c_prog: cover property ($rose(FLASH_PROG_OUT));
    c_erase: cover property ($rose(FLASH_ERASE_OUT));
    c_last_col: cover property (FLASH_WSTB_OUT && FLASH_COL_OUT == 5'h1f);
endmodule
bind pfw_row_writer pfw_rw_checker pfw_rw_checker_i (.*);
`default_nettype wire

// ==== verif/pfw_row_writer_tb_top.sv ====
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module pfw_row_writer_tb_top
    import pfw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e; logic [1:0] s;} pfw_row_t2_t;
    logic        clk, rst_b, awv, wv, arv, fbusy, awrdy, wrdy, bvalid, arrdy, rvalid;
    logic        wstb, prog, erase, busy, seen_erase;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rdata, d;
    logic [3:0]  ws;
    logic [1:0]  bresp, rresp, r;
    logic [9:0]  row, row_seen;
    logic [4:0]  col;
    pfw_word_t   wdat;
    pfw_word_t   cap [32];
    int          n_errors, num_checks, cyc, nstb, fb_cnt;
    pfw_row_t2_t tbl [6] = '{'{8'h00, 32'ha5, 32'ha5, 2'h0}, '{8'h04, 32'hff, 32'h7f, 2'h0},
        '{8'h08, 32'h134, 32'h34, 2'h0}, '{8'h0c, 32'hff, 32'h3f, 2'h0},
        '{8'h14, 32'h55, 32'h0, 2'h0}, '{8'h18, 32'hff, 32'h0, 2'h2}};

    pfw_row_writer pfw_row_writer_i (.CORE_CLK_IN(clk), .RST_B_IN(rst_b),
        .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awrdy), .S_AXI_AWADDR_IN(awa),
        .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrdy), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(ws),
        .S_AXI_BVALID_OUT(bvalid), .S_AXI_BREADY_IN(1'b1), .S_AXI_BRESP_OUT(bresp),
        .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arrdy), .S_AXI_ARADDR_IN(ara),
        .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(1'b1), .S_AXI_RDATA_OUT(rdata),
        .S_AXI_RRESP_OUT(rresp), .FLASH_BUSY_IN(fbusy), .FLASH_ROW_OUT(row), .FLASH_COL_OUT(col),
        .FLASH_WDATA_OUT(wdat), .FLASH_WSTB_OUT(wstb), .FLASH_PROG_OUT(prog),
        .FLASH_ERASE_OUT(erase), .BUSY_OUT(busy));

    // Free-running core clock.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Array stand-in: busy for six cycles per request; also records strobed words.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            summarize();
        end
        if (fb_cnt != 0) begin
            fb_cnt <= fb_cnt - 1;
            if (fb_cnt == 1) fbusy <= 1'b0;
        end else if ((prog || erase) && !fbusy) begin
            fbusy <= 1'b1;
            fb_cnt <= 6;
        end
        if (erase) seen_erase <= 1'b1;
        if (wstb) begin
            cap[col] <= wdat;
            row_seen <= row;
            nstb <= nstb + 1;
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1;
        do begin
            @(posedge clk);
            if (awrdy) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (!bvalid);
        r = bresp;
    endtask

    task automatic rd(input logic [7:0] a);
        ara <= a; arv <= 1'b1;
        do begin
            @(posedge clk);
            if (arrdy) arv <= 1'b0;
        end while (!rvalid);
        d = rdata; r = rresp;
    endtask

    // Two keys then the control write, with nothing in between.
    task automatic op(input logic [31:0] c);
        wr(8'h14, 32'h55); wr(8'h14, 32'haa); wr(8'h10, c);
    endtask

    task automatic idle();
        while (busy !== 1'b0) @(posedge clk);
    endtask

    task automatic summarize();
        $display("n_errors=%0d num_checks=%0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Main sequence: register table, then latch loads, commits and erase.
    initial begin
        rst_b = 1'b0; awv = 1'b0; wv = 1'b0; arv = 1'b0; fbusy = 1'b0; ws = 4'hf;
        awa = 8'h00; ara = 8'h00; wd = 32'h0; cyc = 0; nstb = 0; fb_cnt = 0; seen_erase = 1'b0;
        repeat (6) @(posedge clk);
        `CHK(busy, 1'b0)
        `CHK(wdat, 14'h3fff)
        rst_b <= 1'b1;
        @(posedge clk);
        foreach (tbl[i]) begin
            wr(tbl[i].a, tbl[i].w);
            `CHK(r, tbl[i].s)
            rd(tbl[i].a);
            `CHK(d, tbl[i].e)
            `CHK(r, tbl[i].s)
        end
        ws <= 4'h0; wr(8'h08, 32'h77); ws <= 4'hf; rd(8'h08);
        `CHK(d, 32'h34)
        wr(8'h04, 32'h03); wr(8'h00, 32'h22); wr(8'h0c, 32'h12); op(32'h26);
        `CHK(busy, 1'b0)
        wr(8'h00, 32'h23); wr(8'h14, 32'h55); wr(8'h08, 32'h99); wr(8'h14, 32'haa);
        wr(8'h10, 32'h26); rd(8'h10);
        `CHK(d[3], 1'b1)
        wr(8'h10, 32'h04); wr(8'h00, 32'h25); wr(8'h08, 32'hbc); wr(8'h0c, 32'h0a);
        op(32'h06);
        `CHK(busy, 1'b1)
        op(32'h26); rd(8'h10);
        `CHK(d[3:1], 3'b011)
        idle();
        `CHK(nstb, 32)
        `CHK(cap[2], 14'h1234)
        `CHK(cap[3], 14'h3fff)
        `CHK(cap[5], 14'h0abc)
        `CHK(cap[0], 14'h3fff)
        `CHK(row_seen, 10'h019)
        `CHK(seen_erase, 1'b0)
        nstb <= 0; wr(8'h00, 32'h27); op(32'h06); idle();
        `CHK(cap[5], 14'h3fff)
        `CHK(cap[7], 14'h0abc)
        nstb <= 0; op(32'h07); idle();
        `CHK(nstb, 0)
        `CHK(seen_erase, 1'b1)
        // Reset in the middle of a commit: nothing is programmed and every latch is blank again.
        nstb <= 0; op(32'h06); rst_b <= 1'b0; repeat (2) @(posedge clk);
        `CHK({busy, wstb, awrdy}, 3'b001)
        rst_b <= 1'b1; @(posedge clk);
        `CHK({busy, prog, wdat}, {2'b00, 14'h3fff})
        op(32'h06); idle();
        `CHK(nstb, 32)
        `CHK(cap[7], 14'h3fff)
        `CHK(cap[0], 14'h0000)
        summarize();
    end
endmodule
`default_nettype wire
